// [hw/led_fade_pwm_controller.sv]
// led fade controller: per-pin fade sequencer, pwm outputs, ahb-lite regs
// assumes button levels synchronous to ref_clk_i, one ahb-lite master
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
module led_fade_pwm_controller
    import led_fade_pkg::*;
#(
    parameter int STEP_UNIT_CYCLES = led_fade_pkg::STEP_UNIT_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [7:0]  button_touched_i,
    output logic      [7:0]  led_pin_o
);
    import led_fade_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0][31:0]    cfg_a;
        logic [NPIN-1:0][31:0]    cfg_b;
        fade_state_t [NPIN-1:0]   st;
        logic [NPIN-1:0][7:0]     idx;
        logic [NPIN-1:0][11:0]    tmr;
        logic [NPIN-1:0][7:0]     cyc;
        logic [NPIN-1:0]          touch_q;
        logic [NPIN-1:0]          pin;
        logic                     wr_pend;
        logic [5:0]               wr_word;
        logic [31:0]              rdata;
        logic                     ready;
        logic                     resp;
    } top_state_t;

    top_state_t r_reg;
    top_state_t r_next;

    logic [NPIN-1:0][8:0] width;

    tick_if tick ();

    pwm_timebase #(
        .STEP_UNIT_CYCLES (STEP_UNIT_CYCLES)
    ) u_timebase (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick      (tick)
    );

    // one mapper per pin, fed from the live index
    for (genvar g = 0; g < NPIN; g++) begin : g_map
        map_if mi ();
        assign mi.index    = r_reg.idx[g];
        assign mi.inverted = r_reg.cfg_a[g][POL_BIT];
        assign mi.log_sel  = r_reg.cfg_a[g][LOG_BIT];
        assign width[g]    = mi.width;
        width_map u_map (
            .m (mi)
        );
    end

    always_comb begin
        logic        sel;
        logic        mapped;
        logic [5:0]  word;
        logic [2:0]  pin_n;
        logic        is_a;
        logic        is_b;
        logic        is_st;
        fade_mode_t  md;
        fade_state_t st;
        logic        tch;
        logic        rel;
        logic        fading;
        logic [7:0]  tgt;
        logic [7:0]  t;
        logic [3:0]  f;
        logic [11:0] ivl;
        logic [7:0]  nidx;
        logic [11:0] ntmr;
        logic        arrived;
        logic [7:0]  cyc1;
        logic [7:0]  rep_max;
        logic [11:0] dly;
        sel     = 1'b0;
        mapped  = 1'b0;
        word    = 6'h00;
        pin_n   = 3'h0;
        is_a    = 1'b0;
        is_b    = 1'b0;
        is_st   = 1'b0;
        md      = MODE_SINGLE;
        st      = ST_IDLE;
        tch     = 1'b0;
        rel     = 1'b0;
        fading  = 1'b0;
        tgt     = 8'h00;
        t       = 8'h00;
        f       = 4'h0;
        ivl     = 12'h000;
        nidx    = 8'h00;
        ntmr    = 12'h000;
        arrived = 1'b0;
        cyc1    = 8'h00;
        rep_max = 8'h00;
        dly     = 12'h000;
        r_next  = r_reg;

        // bus data phase: commit pending write
        if (r_reg.wr_pend) begin
            pin_n = r_reg.wr_word[2:0];
            if (r_reg.wr_word[3]) begin
                r_next.cfg_b[pin_n] = hwdata_i;
            end else begin
                r_next.cfg_a[pin_n] = hwdata_i;
            end
        end

        // bus address phase
        r_next.wr_pend = 1'b0;
        r_next.ready   = 1'b1;
        r_next.resp    = 1'b0;
        r_next.rdata   = 32'h0000_0000;
        sel    = hsel_i & htrans_i[1] & hready_i;
        word   = haddr_i[7:2];
        mapped = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0)
                 && (word < WORD_LIMIT);
        // region decode: status, word b, word a
        is_st  = mapped && (word >= 6'(STAT_BASE >> 2));
        is_b   = mapped && !is_st && (word >= 6'(CFG_B_BASE >> 2));
        is_a   = mapped && !is_st && !is_b;
        // status words are read only, writes dropped
        if (sel && mapped && hwrite_i) begin
            r_next.wr_pend = !is_st;
            r_next.wr_word = word;
        end
        // status from live state, config words forwarded
        if (sel && mapped && !hwrite_i) begin
            pin_n = word[2:0];
            if (is_st) begin
                r_next.rdata[ST_IDX_LSB +: 8] = r_reg.idx[pin_n];
                r_next.rdata[ST_FSM_LSB +: 3] = r_reg.st[pin_n];
                r_next.rdata[ST_CYC_LSB +: 8] = r_reg.cyc[pin_n];
            end else if (is_b) begin
                r_next.rdata = r_next.cfg_b[pin_n];
            end else if (is_a) begin
                r_next.rdata = r_next.cfg_a[pin_n];
            end
        end

        // per-pin fade sequencer, own mode per pin
        for (int i = 0; i < NPIN; i++) begin
            md  = fade_mode_t'(r_reg.cfg_a[i][MODE_LSB +: 2]);
            st  = r_reg.st[i];
            tch = button_touched_i[i] & ~r_reg.touch_q[i];
            rel = ~button_touched_i[i] & r_reg.touch_q[i];
            r_next.touch_q[i] = button_touched_i[i];

            fading = (st == ST_FADE_IN) || (st == ST_FADE_OUT);
            if (st == ST_FADE_IN) begin
                tgt = r_reg.cfg_a[i][ON_LSB +: 8];
                t   = r_reg.cfg_b[i][UP_T_LSB +: 8];
                f   = r_reg.cfg_b[i][UP_F_LSB +: 4];
            end else begin
                tgt = r_reg.cfg_a[i][OFF_LSB +: 8];
                t   = r_reg.cfg_b[i][DN_T_LSB +: 8];
                f   = r_reg.cfg_b[i][DN_F_LSB +: 4];
            end
            // step interval is time times factor, a factor of 0 counts as 1
            if (f == 4'h0) begin
                ivl = {4'h0, t};
            end else begin
                ivl = {4'h0, t} * {8'h00, f};
            end
            nidx = r_reg.idx[i];
            ntmr = r_reg.tmr[i];
            if (t == 8'h00) begin
                nidx = tgt;
            end else if (r_reg.idx[i] != tgt && tick.step_tick) begin
                if (r_reg.tmr[i] >= ivl - 12'h001) begin
                    ntmr = 12'h000;
                    if (r_reg.idx[i] < tgt) begin
                        nidx = r_reg.idx[i] + 8'h01;
                    end else begin
                        nidx = r_reg.idx[i] - 8'h01;
                    end
                end else begin
                    ntmr = r_reg.tmr[i] + 12'h001;
                end
            end
            arrived = (nidx == tgt);
            if (fading) begin
                r_next.idx[i] = nidx;
                r_next.tmr[i] = ntmr;
            end

            if (r_reg.cyc[i] == 8'hFF) begin
                cyc1 = 8'hFF;
            end else begin
                cyc1 = r_reg.cyc[i] + 8'h01;
            end
            rep_max = r_reg.cfg_a[i][CNT_LSB +: 8];
            if (rep_max == 8'h00) begin
                rep_max = 8'h01;
            end
            dly = {4'h0, r_reg.cfg_a[i][CNT_LSB +: 8]} << OFF_DELAY_SHIFT;
            // in continuous mode, releasing restarts the post-release cycle count
            if (rel && md == MODE_CONTINUOUS) begin
                r_next.cyc[i] = 8'h00;
            end

            if (r_reg.cfg_a[i][HOST_BIT]) begin
                // host intensity, same table as fading
                r_next.st[i]  = ST_IDLE;
                r_next.idx[i] = r_reg.cfg_b[i][HPWM_LSB +: 8];
                r_next.tmr[i] = 12'h000;
                r_next.cyc[i] = 8'h00;
            end else begin
                unique case (st)
                    ST_IDLE: begin
                        // index holds its last target here
                        if (tch) begin
                            r_next.st[i]  = ST_FADE_IN;
                            r_next.tmr[i] = 12'h000;
                            r_next.cyc[i] = 8'h00;
                        end
                    end
                    ST_FADE_IN: begin
                        if (md == MODE_SINGLE && rel) begin
                            r_next.tmr[i] = 12'h000;
                            r_next.st[i]  = (dly == 12'h000) ? ST_FADE_OUT
                                                             : ST_DELAY;
                        end else if (arrived) begin
                            r_next.tmr[i] = 12'h000;
                            r_next.st[i]  = (md == MODE_SINGLE) ? ST_HOLD_ON
                                                                : ST_FADE_OUT;
                        end
                    end
                    ST_HOLD_ON: begin
                        if (rel || !button_touched_i[i]) begin
                            r_next.tmr[i] = 12'h000;
                            r_next.st[i]  = (dly == 12'h000) ? ST_FADE_OUT
                                                             : ST_DELAY;
                        end
                    end
                    ST_DELAY: begin
                        if (tch) begin
                            r_next.tmr[i] = 12'h000;
                            r_next.st[i]  = ST_FADE_IN;
                        end else if (tick.step_tick) begin
                            r_next.tmr[i] = r_reg.tmr[i] + 12'h001;
                            if (r_reg.tmr[i] + 12'h001 >= dly) begin
                                r_next.tmr[i] = 12'h000;
                                r_next.st[i]  = ST_FADE_OUT;
                            end
                        end
                    end
                    ST_FADE_OUT: begin
                        if (md == MODE_SINGLE && tch) begin
                            r_next.tmr[i] = 12'h000;
                            r_next.st[i]  = ST_FADE_IN;
                        end else if (arrived) begin
                            // one full in-then-out cycle done
                            r_next.tmr[i] = 12'h000;
                            if (!rel || md != MODE_CONTINUOUS) begin
                                r_next.cyc[i] = cyc1;
                            end
                            r_next.st[i] = ST_IDLE;
                            if (md == MODE_CONTINUOUS) begin
                                if (button_touched_i[i]) begin
                                    r_next.st[i] = ST_FADE_IN;
                                end else if (!rel && cyc1 <= rep_max
                                             && r_reg.cfg_a[i][CNT_LSB +: 8]
                                                != 8'h00) begin
                                    r_next.st[i] = ST_FADE_IN;
                                end
                            end else if (md == MODE_REPEAT) begin
                                if (cyc1 < rep_max) begin
                                    r_next.st[i] = ST_FADE_IN;
                                end
                            end
                            // repeat stops at count even if touched
                        end
                    end
                    default: begin
                        r_next.st[i] = ST_IDLE;
                    end
                endcase
            end

            // pwm pin high while count below pulse width
            if (tick.pwm_tick) begin
                if (width[i] > {1'b0, tick.pwm_count}) begin
                    r_next.pin[i] = 1'b1;
                end else begin
                    r_next.pin[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg       <= '0;
            r_reg.cfg_a <= {NPIN{CFG_A_RESET}};
            r_reg.cfg_b <= {NPIN{CFG_B_RESET}};
            r_reg.ready <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hrdata_o    = r_reg.rdata;
    assign hreadyout_o = r_reg.ready;
    assign hresp_o     = r_reg.resp;
    assign led_pin_o   = r_reg.pin;
endmodule : led_fade_pwm_controller

// [hw/pwm_timebase.sv]
// timebase: 2 mhz pwm enable, 8-bit pwm count, fade step unit enable
// assumes the 250 mhz reference clock and an async active-high reset
`timescale 1ns/10ps
module pwm_timebase
    import led_fade_pkg::*;
#(
    parameter int STEP_UNIT_CYCLES = STEP_UNIT_CYC
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    tick_if.src       tick
);
    typedef struct packed {
        logic [6:0]  div;
        logic [7:0]  cnt;
        logic [17:0] unit;
        logic        pwm_tick;
        logic        step_tick;
    } tb_state_t;

    tb_state_t r_reg;
    tb_state_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.pwm_tick  = 1'b0;
        r_next.step_tick = 1'b0;
        // 2 mhz enable, 256-step period
        if (r_reg.div == 7'(PWM_DIV - 1)) begin
            r_next.div      = 7'h00;
            r_next.pwm_tick = 1'b1;
            r_next.cnt      = r_reg.cnt + 8'h01;
        end else begin
            r_next.div = r_reg.div + 7'h01;
        end
        if (r_reg.unit == 18'(STEP_UNIT_CYCLES - 1)) begin
            r_next.unit      = 18'h00000;
            r_next.step_tick = 1'b1;
        end else begin
            r_next.unit = r_reg.unit + 18'h00001;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick.pwm_tick  = r_reg.pwm_tick;
    assign tick.step_tick = r_reg.step_tick;
    assign tick.pwm_count = r_reg.cnt;
endmodule : pwm_timebase

// [hw/width_map.sv]
// intensity index to pwm pulse width, linear or log, either polarity
// assumes a combinational user that registers the result
`timescale 1ns/10ps
module width_map
    import led_fade_pkg::*;
(
    map_if.mapper m
);
    logic [8:0] lin_w;
    logic [8:0] log_w;

    always_comb begin
        lin_w = 9'h000;
        log_w = LOG_WIDTH[m.index];
        if (m.inverted) begin
            // mirrored tables
            lin_w = (m.index == 8'hFF) ? 9'h000 : 9'h100 - {1'b0, m.index};
            log_w = 9'h100 - LOG_WIDTH[m.index];
        end else begin
            // 0 maps to 0, n maps to n+1
            lin_w = (m.index == 8'h00) ? 9'h000 : {1'b0, m.index} + 9'h001;
        end
        m.width = m.log_sel ? log_w : lin_w;
    end
endmodule : width_map

// [include/fade_carriers.sv]
// carriers between the controller and its timebase and width mappers
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface tick_if;
    logic       pwm_tick;
    logic       step_tick;
    logic [7:0] pwm_count;
    modport src (output pwm_tick, output step_tick, output pwm_count);
    modport snk (input pwm_tick, input step_tick, input pwm_count);
endinterface : tick_if

interface map_if;
    logic [7:0] index;
    logic       inverted;
    logic       log_sel;
    logic [8:0] width;
    modport mapper (input index, input inverted, input log_sel,
                    output width);
    modport user (output index, output inverted, output log_sel,
                  input width);
endinterface : map_if

// [include/led_fade_pkg.sv]
// led fade controller package: map, fields, reset values, timing, tables
// assumes a single 250 MHz clock and an ahb-lite register port
package led_fade_pkg;
    localparam int NPIN  = 8;
    localparam int IDX_W = 8;
    // timing
    localparam int REF_CLK_HZ      = 250_000_000;
    localparam int PWM_CLK_HZ      = 2_000_000;
    localparam int PWM_DIV         = REF_CLK_HZ / PWM_CLK_HZ;
    localparam int STEP_UNIT_US    = 1000;
    localparam int STEP_UNIT_CYC   = STEP_UNIT_US * (REF_CLK_HZ / 1_000_000);
    localparam int OFF_DELAY_SHIFT = 4;
    // register map (byte addresses)
    localparam logic [7:0] CFG_A_BASE = 8'h00;
    localparam logic [7:0] CFG_B_BASE = 8'h20;
    localparam logic [7:0] STAT_BASE  = 8'h40;
    localparam logic [5:0] WORD_LIMIT = 6'h18;
    // pin configuration word a
    localparam int ON_LSB   = 0;
    localparam int OFF_LSB  = 8;
    localparam int CNT_LSB  = 16;
    localparam int MODE_LSB = 24;
    localparam int POL_BIT  = 26;
    localparam int LOG_BIT  = 27;
    localparam int HOST_BIT = 28;
    // pin configuration word b
    localparam int UP_T_LSB = 0;
    localparam int DN_T_LSB = 8;
    localparam int UP_F_LSB = 16;
    localparam int DN_F_LSB = 20;
    localparam int HPWM_LSB = 24;
    // pin status word
    localparam int ST_IDX_LSB = 0;
    localparam int ST_FSM_LSB = 8;
    localparam int ST_CYC_LSB = 16;
    // reset values: inverted polarity, logarithmic map, on ff, off 00
    localparam logic [31:0] CFG_A_RESET = 32'h0C00_00FF;
    localparam logic [31:0] CFG_B_RESET = 32'h0011_0A0A;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_FADE_IN  = 3'b001,
        ST_HOLD_ON  = 3'b010,
        ST_DELAY    = 3'b011,
        ST_FADE_OUT = 3'b100
    } fade_state_t;

    typedef enum logic [1:0] {
        MODE_SINGLE     = 2'b00,
        MODE_CONTINUOUS = 2'b01,
        MODE_REPEAT     = 2'b10
    } fade_mode_t;

    // logarithmic pulse widths, normal polarity
    localparam logic [0:255][8:0] LOG_WIDTH = '{
        9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h002, 9'h002, 9'h002,
        9'h002, 9'h002, 9'h002, 9'h002, 9'h002, 9'h002, 9'h003, 9'h003,
        9'h003, 9'h003, 9'h003, 9'h003, 9'h003, 9'h003, 9'h003, 9'h004,
        9'h004, 9'h004, 9'h004, 9'h004, 9'h004, 9'h004, 9'h004, 9'h005,
        9'h005, 9'h005, 9'h005, 9'h005, 9'h005, 9'h006, 9'h006, 9'h006,
        9'h006, 9'h006, 9'h007, 9'h007, 9'h007, 9'h007, 9'h007, 9'h008,
        9'h008, 9'h008, 9'h008, 9'h009, 9'h009, 9'h009, 9'h009, 9'h00A,
        9'h00A, 9'h00A, 9'h00A, 9'h00B, 9'h00B, 9'h00B, 9'h00C, 9'h00C,
        9'h00C, 9'h00D, 9'h00D, 9'h00D, 9'h00E, 9'h00E, 9'h00E, 9'h00F,
        9'h00F, 9'h00F, 9'h010, 9'h010, 9'h010, 9'h011, 9'h011, 9'h012,
        9'h012, 9'h013, 9'h013, 9'h014, 9'h014, 9'h015, 9'h015, 9'h016,
        9'h016, 9'h017, 9'h017, 9'h018, 9'h018, 9'h019, 9'h019, 9'h01A,
        9'h01A, 9'h01B, 9'h01B, 9'h01C, 9'h01D, 9'h01D, 9'h01E, 9'h01E,
        9'h01F, 9'h020, 9'h020, 9'h021, 9'h021, 9'h022, 9'h023, 9'h023,
        9'h024, 9'h025, 9'h026, 9'h026, 9'h027, 9'h028, 9'h028, 9'h029,
        9'h02A, 9'h02B, 9'h02C, 9'h02C, 9'h02D, 9'h02E, 9'h02F, 9'h030,
        9'h030, 9'h031, 9'h032, 9'h033, 9'h034, 9'h035, 9'h036, 9'h037,
        9'h037, 9'h038, 9'h039, 9'h03A, 9'h03B, 9'h03C, 9'h03D, 9'h03E,
        9'h03F, 9'h040, 9'h041, 9'h042, 9'h043, 9'h044, 9'h045, 9'h047,
        9'h048, 9'h049, 9'h04A, 9'h04B, 9'h04C, 9'h04D, 9'h04E, 9'h050,
        9'h051, 9'h052, 9'h053, 9'h054, 9'h056, 9'h057, 9'h058, 9'h059,
        9'h05B, 9'h05C, 9'h05D, 9'h05F, 9'h060, 9'h061, 9'h063, 9'h064,
        9'h065, 9'h067, 9'h068, 9'h06A, 9'h06B, 9'h06D, 9'h06E, 9'h06F,
        9'h071, 9'h072, 9'h074, 9'h075, 9'h077, 9'h079, 9'h07A, 9'h07C,
        9'h07D, 9'h07F, 9'h081, 9'h082, 9'h084, 9'h085, 9'h087, 9'h089,
        9'h08B, 9'h08C, 9'h08E, 9'h090, 9'h092, 9'h093, 9'h095, 9'h097,
        9'h099, 9'h09B, 9'h09C, 9'h09E, 9'h0A0, 9'h0A2, 9'h0A4, 9'h0A6,
        9'h0A8, 9'h0AA, 9'h0AC, 9'h0AE, 9'h0B0, 9'h0B2, 9'h0B4, 9'h0B6,
        9'h0B8, 9'h0BA, 9'h0BC, 9'h0BE, 9'h0C0, 9'h0C2, 9'h0C5, 9'h0C7,
        9'h0C9, 9'h0CB, 9'h0CD, 9'h0D0, 9'h0D2, 9'h0D4, 9'h0D7, 9'h0D9,
        9'h0DB, 9'h0DD, 9'h0E0, 9'h0E2, 9'h0E5, 9'h0E7, 9'h0E9, 9'h0EC,
        9'h0EE, 9'h0F1, 9'h0F3, 9'h0F6, 9'h0F8, 9'h0FB, 9'h0FD, 9'h100
    };
endpackage : led_fade_pkg

// [verification/led_fade_sva.sv]
// checker: bus answers and pwm output timing
// assumes hready_i is tied to hreadyout_o
`timescale 1ns/10ps
module led_fade_sva (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [7:0]  led_pin_o
);
    logic        rd_reg, wr_reg, take;
    logic [31:0] adr_reg, wa_reg, wd_reg;
    logic [7:0]  gap_reg;
    assign take = hsel_i & htrans_i[1] & hready_i;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
            adr_reg <= 32'h0;
            wa_reg  <= 32'hFFFF_FFFF;
            wd_reg  <= 32'h0;
            gap_reg <= 8'hFF;
        end else begin
            rd_reg  <= take & ~hwrite_i;
            wr_reg  <= take & hwrite_i;
            adr_reg <= take ? haddr_i : adr_reg;
            wa_reg  <= wr_reg ? adr_reg : wa_reg;
            wd_reg  <= wr_reg ? hwdata_i : wd_reg;
            gap_reg <= $changed(led_pin_o) ? 8'h00
                     : gap_reg + {7'h0, gap_reg != 8'hFF};
        end
    end
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    ready_high_a: assert property (hreadyout_o)
        else $error("wait state inserted");
    resp_okay_a: assert property (!hresp_o)
        else $error("error response");
    rdata_idle_a: assert property (!rd_reg |-> hrdata_o == 32'h0)
        else $error("read data outside data phase");
    unmapped_zero_a: assert property (rd_reg && (adr_reg[31:5] > 27'h2
        || adr_reg[1:0] != 2'b00) |-> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    state_range_a: assert property (rd_reg && adr_reg[31:5] == 27'h2
        |-> hrdata_o[10:8] <= 3'h4)
        else $error("bad fade state");
    cfg_readback_a: assert property (
        rd_reg && adr_reg == wa_reg && adr_reg[31:5] == 27'h0
        && adr_reg[1:0] == 2'b00 |-> hrdata_o[28:0] == wd_reg[28:0])
        else $error("config word lost");
    tick_spacing_a: assert property (
        $changed(led_pin_o) |-> gap_reg >= 8'd124)
        else $error("pin changed off the pwm tick");
    pin_hold_a: assert property (
        $changed(led_pin_o) |=> $stable(led_pin_o) [*8])
        else $error("pin not held");
endmodule : led_fade_sva

bind led_fade_pwm_controller led_fade_sva u_sva (
    .ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .led_pin_o
);

// [verification/led_load.sv]
// led model: counts reference cycles in which one pin is lit
// assumes the pin is sampled on the reference clock
`timescale 1ns/10ps
module led_load #(
    parameter int PIN = 0
) (
    input  wire logic        clk_i,
    input  wire logic [7:0]  pin_i,
    input  wire logic        clear_i,
    output logic      [15:0] lit_cycles_o
);
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            lit_cycles_o <= 16'h0000;
        end else if (pin_i[PIN]) begin
            lit_cycles_o <= lit_cycles_o + 16'h0001;
        end
    end
endmodule : led_load

// [verification/test_led_fade_pwm_controller.sv]
// bench: bus tasks, fade scenarios, pwm duty on pins 5 and 6
// assumes controller, carriers, led model and checker compiled
`timescale 1ns/10ps
module test_led_fade_pwm_controller;
    logic        clk, rst, hsel, hwrite, hrdy, hresp, clr;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [7:0]  btn, pin;
    logic [15:0] lit, lit6;
    int          n_fail = 0, checks = 0, cyc = 0, t0;
    led_fade_pwm_controller #(.STEP_UNIT_CYCLES(4)) DUT (
        .ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .button_touched_i(btn),
        .led_pin_o(pin));
    led_load #(.PIN(5)) LED (.clk_i(clk), .pin_i(pin), .clear_i(clr),
        .lit_cycles_o(lit));
    led_load #(.PIN(6)) LED6 (.clk_i(clk), .pin_i(pin), .clear_i(clr),
        .lit_cycles_o(lit6));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        v = hrdata;
    endtask : bus
    task cfg(input logic [31:0] p, input logic [31:0] a, b);
        bus(1'b1, p << 2, a);
        bus(1'b1, 32'h20 + (p << 2), b);
        bus(1'b0, p << 2, 32'h0);
        chk(v[28:0], a[28:0]);
    endtask : cfg
    task wst(input logic [31:0] p, input logic [2:0] s);
        t0 = cyc;
        repeat (200) begin
            bus(1'b0, 32'h40 + (p << 2), 32'h0);
            if (v[10:8] === s) break;
        end
        t0 = cyc - t0;
    endtask : wst
    task test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        {hsel, hwrite, htrans, clr, btn} = '0;
        {haddr, hwdata} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (200) @(posedge clk);
        chk(pin, 8'hFF);
        bus(1'b0, 32'h00, 32'h0);
        chk(v, 32'h0C00_00FF);
        bus(1'b0, 32'h20, 32'h0);
        chk(v, 32'h0011_0A0A);
        bus(1'b1, 32'h40, 32'hFFFF_FFFF);
        bus(1'b0, 32'h40, 32'h0);
        chk(v, 32'h0);
        bus(1'b0, 32'h60, 32'h0);
        chk(v, 32'h0);
        $display("done reset");
        cfg(1, 32'h0000_00FF, 32'h0);
        repeat (260) @(posedge clk);
        chk(pin[1], 1'b0);
        btn <= 8'h02;
        wst(1, 3'd2);
        chk(t0 < 12, 1'b1);
        chk(v[7:0], 8'hFF);
        repeat (260) @(posedge clk);
        chk(pin[1], 1'b1);
        btn <= 8'h00;
        wst(1, 3'd0);
        chk(v[7:0], 8'h00);
        repeat (260) @(posedge clk);
        chk(pin[1], 1'b0);
        $display("done static");
        cfg(2, 32'h0001_0008, 32'h0023_0102);
        btn <= 8'h04;
        wst(2, 3'd2);
        chk(t0 >= 160 && t0 <= 212, 1'b1);
        chk(v[7:0], 8'h08);
        btn <= 8'h00;
        wst(2, 3'd4);
        chk(t0 >= 56 && t0 <= 76, 1'b1);
        wst(2, 3'd0);
        chk(t0 >= 56 && t0 <= 76, 1'b1);
        $display("done timed fade");
        cfg(3, 32'h0100_0002, 32'h0);
        cfg(4, 32'h0203_0002, 32'h0);
        btn <= 8'h18;
        repeat (100) @(posedge clk);
        bus(1'b0, 32'h4C, 32'h0);
        chk(v[23:16] > 8'd4, 1'b1);
        bus(1'b0, 32'h50, 32'h0);
        chk(v[23:0], 24'h03_0000);
        btn <= 8'h10;
        repeat (30) @(posedge clk);
        bus(1'b0, 32'h4C, 32'h0);
        chk(v[10:0], 11'h0);
        $display("done cycle modes");
        cfg(5, 32'h1800_0000, 32'h7F00_0000);
        cfg(6, 32'h1400_0000, 32'h4000_0000);
        repeat (300) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (32001) @(posedge clk);
        chk(lit, 16'd6000);
        chk(lit6, 16'd24000);
        $display("done log duty");
        test_done();
    end
endmodule : test_led_fade_pwm_controller
